// *** design/operand_address_pkg.sv ***
// shared constants and types for the operand effective-address unit
package operand_address_pkg;
  localparam int WORD_W = 16;
  localparam int REG_COUNT = 8;
  localparam logic [2:0] PROGRAM_COUNTER_NUM = 3'h7;
  localparam logic [2:0] STACK_POINTER_NUM = 3'h6;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // specifier field positions
  localparam int SRC_MODE_HI = 11;
  localparam int SRC_MODE_LO = 9;
  localparam int SRC_REG_HI = 8;
  localparam int SRC_REG_LO = 6;
  localparam int DST_MODE_HI = 5;
  localparam int DST_MODE_LO = 3;
  localparam int DST_REG_HI = 2;
  localparam int DST_REG_LO = 0;
  localparam int BYTE_FLAG_BIT = 15;
  // operand mode codes
  localparam logic [2:0] MODE_REGISTER = 3'h0;
  localparam logic [2:0] MODE_REG_DEFERRED = 3'h1;
  localparam logic [2:0] MODE_AUTOINC = 3'h2;
  localparam logic [2:0] MODE_AUTOINC_DEFERRED = 3'h3;
  localparam logic [2:0] MODE_AUTODEC = 3'h4;
  localparam logic [2:0] MODE_AUTODEC_DEFERRED = 3'h5;
  localparam logic [2:0] MODE_INDEX = 3'h6;
  localparam logic [2:0] MODE_INDEX_DEFERRED = 3'h7;
  typedef enum logic [2:0] {
    OP_ADD,
    OP_CLEAR,
    OP_COMPLEMENT,
    OP_INCREMENT,
    OP_NONE
  } op_kind_t;
endpackage

// *** design/step_size.sv ***
// register step amount for auto-increment and auto-decrement
module step_size
(
  input wire logic [2:0] mode,
  input wire logic [2:0] reg_num,
  input wire logic byte_op,
  output logic [15:0] step
);
  always_comb
  begin
    // deferred modes step over a pointer word, so always two
    if (mode == operand_address_pkg::MODE_AUTOINC_DEFERRED
        || mode == operand_address_pkg::MODE_AUTODEC_DEFERRED)
      step = operand_address_pkg::WORD_STEP;
    else if (reg_num == operand_address_pkg::PROGRAM_COUNTER_NUM)
      step = operand_address_pkg::WORD_STEP;
    else if (reg_num == operand_address_pkg::STACK_POINTER_NUM)
      step = operand_address_pkg::WORD_STEP;
    else if (byte_op)
      step = operand_address_pkg::BYTE_STEP;
    else
      step = operand_address_pkg::WORD_STEP;
  end
endmodule

// *** design/operand_address_unit.sv ***
// operand effective-address sequencer with general registers and word memory port
//==============================================================
module operand_address_unit
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  output logic mem_req,
  output logic mem_write,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic busy,
  output logic [15:0] program_counter,
  output logic [15:0] stack_pointer
);
  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_SPEC, S_EXT, S_PTR, S_OPER, S_EXEC, S_WRITE
  } state_t;

  //==============================================================
  // state
  state_t state, next_state;
  logic [15:0] regs [8];
  logic [15:0] next_regs [8];
  logic [15:0] instr, next_instr;
  logic phase_dst, next_phase_dst;
  logic [15:0] ea, next_ea;
  logic [15:0] src_val, next_src_val;
  logic [15:0] dst_val, next_dst_val;
  logic [15:0] dst_ea, next_dst_ea;
  logic next_mem_req, next_mem_write;
  logic [15:0] next_mem_addr, next_mem_wdata;
  logic [2:0] mode, rnum;
  logic byte_op;
  logic [15:0] step;
  operand_address_pkg::op_kind_t op;

  assign mode = phase_dst ? instr[operand_address_pkg::DST_MODE_HI:operand_address_pkg::DST_MODE_LO]
                          : instr[operand_address_pkg::SRC_MODE_HI:operand_address_pkg::SRC_MODE_LO];
  assign rnum = phase_dst ? instr[operand_address_pkg::DST_REG_HI:operand_address_pkg::DST_REG_LO]
                          : instr[operand_address_pkg::SRC_REG_HI:operand_address_pkg::SRC_REG_LO];
  assign byte_op = instr[operand_address_pkg::BYTE_FLAG_BIT];

  step_size u_step
  (
    .mode(mode),
    .reg_num(rnum),
    .byte_op(byte_op),
    .step(step)
  );

  // small opcode decode for the handful of operations the unit runs
  always_comb
  begin
    if (instr[14:12] == 3'h6)
      op = operand_address_pkg::OP_ADD;
    else if (instr[14:6] == 9'h028)
      op = operand_address_pkg::OP_CLEAR;
    else if (instr[14:6] == 9'h029)
      op = operand_address_pkg::OP_COMPLEMENT;
    else if (instr[14:6] == 9'h02a)
      op = operand_address_pkg::OP_INCREMENT;
    else
      op = operand_address_pkg::OP_NONE;
  end

  //==============================================================
  // sequencer
  always_comb
  begin
    next_state = state;
    next_regs = regs;
    next_instr = instr;
    next_phase_dst = phase_dst;
    next_ea = ea;
    next_src_val = src_val;
    next_dst_val = dst_val;
    next_dst_ea = dst_ea;
    next_mem_req = mem_req;
    next_mem_write = mem_write;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    unique case (state)
      S_IDLE:
      begin
        if (start)
        begin
          next_mem_req = 1'b1;
          next_mem_write = 1'b0;
          next_mem_addr = regs[operand_address_pkg::PROGRAM_COUNTER_NUM];
          next_state = S_FETCH;
        end
      end
      S_FETCH:
      begin
        if (mem_ack)
        begin
          next_mem_req = 1'b0;
          next_instr = mem_rdata;
          next_regs[operand_address_pkg::PROGRAM_COUNTER_NUM] =
            regs[operand_address_pkg::PROGRAM_COUNTER_NUM] + operand_address_pkg::WORD_STEP;
          // single-operand instructions skip the source phase
          next_phase_dst = (mem_rdata[14:12] != 3'h6);
          next_state = S_SPEC;
        end
      end
      S_SPEC:
      begin
        // register seven takes the same mode arms as any other register, but always steps by two and indexes from the advanced counter
        unique case (mode)
          operand_address_pkg::MODE_REGISTER:
          begin
            if (phase_dst)
              next_dst_val = regs[rnum];
            else
              next_src_val = regs[rnum];
            next_state = phase_dst ? S_EXEC : S_SPEC;
            next_phase_dst = 1'b1;
          end
          operand_address_pkg::MODE_REG_DEFERRED:
          begin
            next_ea = regs[rnum];
            next_mem_req = 1'b1;
            next_mem_addr = regs[rnum];
            next_state = S_OPER;
          end
          operand_address_pkg::MODE_AUTOINC, operand_address_pkg::MODE_AUTOINC_DEFERRED:
          begin
            // pointer taken then register (or counter) advanced
            next_ea = regs[rnum];
            next_mem_req = 1'b1;
            next_mem_addr = regs[rnum];
            next_regs[rnum] = regs[rnum] + step;
            next_state = (mode == operand_address_pkg::MODE_AUTOINC) ? S_OPER : S_PTR;
          end
          operand_address_pkg::MODE_AUTODEC, operand_address_pkg::MODE_AUTODEC_DEFERRED:
          begin
            next_ea = regs[rnum] - step;
            next_regs[rnum] = regs[rnum] - step;
            next_mem_req = 1'b1;
            next_mem_addr = regs[rnum] - step;
            next_state = (mode == operand_address_pkg::MODE_AUTODEC) ? S_OPER : S_PTR;
          end
          operand_address_pkg::MODE_INDEX, operand_address_pkg::MODE_INDEX_DEFERRED:
          begin
            // indexed forms: extension word taken through the counter
            next_mem_req = 1'b1;
            next_mem_addr = regs[operand_address_pkg::PROGRAM_COUNTER_NUM];
            next_state = S_EXT;
          end
        endcase
      end
      S_EXT:
      begin
        if (mem_ack)
        begin
          // source extension consumed first, counter advanced
          next_regs[operand_address_pkg::PROGRAM_COUNTER_NUM] =
            regs[operand_address_pkg::PROGRAM_COUNTER_NUM] + operand_address_pkg::WORD_STEP;
          // with register seven the base is the already advanced counter
          if (rnum == operand_address_pkg::PROGRAM_COUNTER_NUM)
            next_ea = mem_rdata + regs[operand_address_pkg::PROGRAM_COUNTER_NUM]
                      + operand_address_pkg::WORD_STEP;
          else
            next_ea = mem_rdata + regs[rnum];
          next_mem_addr = next_ea;
          next_state = (mode == operand_address_pkg::MODE_INDEX_DEFERRED) ? S_PTR : S_OPER;
        end
      end
      S_PTR:
      begin
        if (mem_ack)
        begin
          next_ea = mem_rdata;
          next_mem_addr = mem_rdata;
          next_state = S_OPER;
        end
      end
      S_OPER:
      begin
        if (mem_ack)
        begin
          next_mem_req = 1'b0;
          if (phase_dst)
          begin
            next_dst_val = mem_rdata;
            next_dst_ea = ea;
            next_state = S_EXEC;
          end
          else
          begin
            next_src_val = mem_rdata;
            next_phase_dst = 1'b1;
            next_state = S_SPEC;
          end
        end
      end
      S_EXEC:
      begin
        unique case (op)
          operand_address_pkg::OP_ADD: next_mem_wdata = src_val + dst_val;
          operand_address_pkg::OP_CLEAR: next_mem_wdata = 16'h0000;
          operand_address_pkg::OP_COMPLEMENT: next_mem_wdata = ~dst_val;
          operand_address_pkg::OP_INCREMENT: next_mem_wdata = dst_val + 16'h0001;
          default: next_mem_wdata = dst_val;
        endcase
        if (mode == operand_address_pkg::MODE_REGISTER)
        begin
          next_regs[rnum] = next_mem_wdata;
          next_state = S_IDLE;
        end
        else
        begin
          next_mem_req = 1'b1;
          next_mem_write = 1'b1;
          next_mem_addr = dst_ea;
          next_state = S_WRITE;
        end
      end
      S_WRITE:
      begin
        if (mem_ack)
        begin
          next_mem_req = 1'b0;
          next_mem_write = 1'b0;
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= S_IDLE;
      for (int i = 0; i < operand_address_pkg::REG_COUNT; i++)
        regs[i] <= operand_address_pkg::REG_RESET;
      instr <= 16'h0000;
      phase_dst <= 1'b0;
      ea <= 16'h0000;
      src_val <= 16'h0000;
      dst_val <= 16'h0000;
      dst_ea <= 16'h0000;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      busy <= 1'b0;
      program_counter <= operand_address_pkg::PC_RESET;
      stack_pointer <= operand_address_pkg::REG_RESET;
    end
    else
    begin
      state <= next_state;
      regs <= next_regs;
      instr <= next_instr;
      phase_dst <= next_phase_dst;
      ea <= next_ea;
      src_val <= next_src_val;
      dst_val <= next_dst_val;
      dst_ea <= next_dst_ea;
      mem_req <= next_mem_req;
      mem_write <= next_mem_write;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      busy <= (next_state != S_IDLE);
      program_counter <= next_regs[operand_address_pkg::PROGRAM_COUNTER_NUM];
      stack_pointer <= next_regs[operand_address_pkg::STACK_POINTER_NUM];
    end
  end
endmodule

// *** test/main_memory_model.sv ***
// behavioural word memory on the far side of the operand address unit
module main_memory_model
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [3:0] cnt;
  //==========================================
  // one word per request after lat wait cycles
  always @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      cnt <= 4'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      // idle data lines flip, so a stale word is never read by luck
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && cnt < lat)
        cnt <= cnt + 4'h1;
      else if (mem_req && !mem_ack)
      begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_write)
          mem[mem_addr[8:1]] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr[8:1]];
      end
    end
endmodule

// *** test/operand_address_asserts.sv ***
// port-level checks for the operand address unit
module operand_address_asserts
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic busy,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] stack_pointer
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic want_instr;
  //==========================================
  // marks the instruction word fetch
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      want_instr <= 1'b0;
    else if (start && !busy)
      want_instr <= 1'b1;
    else if (mem_req && mem_ack)
      want_instr <= 1'b0;
  //==========================================
  // sequences
  sequence s_take;
    start && !busy;
  endsequence
  sequence s_pc_read;
    mem_req && mem_ack && !mem_write && mem_addr == program_counter;
  endsequence
  sequence s_imm_fetch;
    want_instr && mem_req && mem_ack && mem_rdata[11:6] == 6'h17;
  endsequence
  //==========================================
  // assertions
  AST_FETCH_AT_PC: assert property (s_take |=> mem_req && !mem_write && busy
    && mem_addr == $past(program_counter)) else $error("fetch not at counter");
  AST_PC_ADVANCE: assert property (s_pc_read |=>
    program_counter == $past(program_counter) + 16'h0002) else $error("counter step wrong");
  AST_IMM_READ: assert property (s_imm_fetch |->
    ##[2:6] (mem_req && !mem_write && mem_addr + 16'h0002 == program_counter))
    else $error("no immediate read");
  AST_REQ_HOLDS: assert property (mem_req && !mem_ack |=> mem_req
    && $stable(mem_addr) && $stable(mem_write)) else $error("request dropped");
  AST_WRITE_LAST: assert property (mem_req && mem_write && mem_ack |=>
    !mem_req ##[0:2] !busy) else $error("access after result write");
  AST_WDATA_HOLD: assert property (mem_req && mem_write && !mem_ack |=>
    $stable(mem_wdata)) else $error("write data moved");
  AST_IDLE_QUIET: assert property (!busy |-> !mem_req) else $error("access while idle");
  AST_DONE_BOUND: assert property (s_take |=> busy ##[1:400] !busy)
    else $error("instruction never ends");
endmodule
bind operand_address_unit operand_address_asserts chk_u (.sys_clk(sys_clk), .resetn(resetn),
  .start(start), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy),
  .program_counter(program_counter), .stack_pointer(stack_pointer));

// *** test/operand_address_unit_test.sv ***
// self-checking bench for the operand address unit
module operand_address_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, resetn, start, mem_req, mem_write, mem_ack, busy;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, program_counter, stack_pointer;
  logic [3:0] lat;
  int fails;
  int checks_done;
  // program from address 0, one word per entry
  // last word is a defined clear, so the mid-run reset never meets an unknown opcode
  localparam logic [15:0] PROG [28] = '{16'h65c0, 16'h0100, 16'h65c1, 16'h0110, 16'h65c6,
    16'h0140, 16'h0a08, 16'h0a99, 16'h0a69, 16'h0ab9, 16'h0004, 16'h0a1f, 16'h0150, 16'h0ab7,
    16'h0142, 16'h0a3f, 16'h014e, 16'h6cb5, 16'h01a0, 16'h01b0, 16'h6e81, 16'h01c0, 16'h0a09,
    16'h8a96, 16'h8a26, 16'h8a1f, 16'h0154, 16'h0a08};
  operand_address_unit dut_u (.sys_clk(sys_clk), .resetn(resetn), .start(start),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy),
    .program_counter(program_counter), .stack_pointer(stack_pointer));
  main_memory_model mem_u (.sys_clk(sys_clk), .resetn(resetn), .lat(lat), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  //==========================================
  // common tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] at(input logic [15:0] a);
    return mem_u.mem[a[8:1]];
  endfunction
  task automatic put(input logic [15:0] a, input logic [15:0] v);
    mem_u.mem[a[8:1]] = v;
  endtask
  task automatic load_mem;
    foreach (PROG[i]) put(16'(2 * i), PROG[i]);
    put(16'h0100, 16'haaaa);
    put(16'h0110, 16'h0120);
    put(16'h0114, 16'h0130);
    put(16'h0120, 16'h0005);
    put(16'h0130, 16'h0007);
    put(16'h0140, 16'h00ff);
    put(16'h0150, 16'h1234);
    put(16'h0160, 16'h0009);
    put(16'h0170, 16'h0172);
    put(16'h0172, 16'hffff);
    put(16'h01a0, 16'h0003);
    put(16'h01b0, 16'h0004);
    put(16'h01c0, 16'h01c4);
    put(16'h01c4, 16'h0010);
  endtask
  // one instruction, bounded wait for busy to fall
  task automatic run1(input logic [15:0] exp_pc);
    int n;
    start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 200)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    check({15'h0000, busy}, 16'h0000);
    check(program_counter, exp_pc);
  endtask
  //==========================================
  // scenarios
  task automatic t_setup;
    run1(16'h0004);
    run1(16'h0008);
    run1(16'h000c);
    check(stack_pointer, 16'h0140);
  endtask
  task automatic t_deferred;
    run1(16'h000e);
    check(at(16'h0100), 16'h0000);
    run1(16'h0010);
    check(at(16'h0120), 16'h0006);
    run1(16'h0012);
    check(at(16'h0120), 16'hfff9);
    run1(16'h0016);
    check(at(16'h0130), 16'h0008);
  endtask
  task automatic t_pc_modes;
    run1(16'h001a);
    check(at(16'h0150), 16'h0000);
    run1(16'h001e);
    check(at(16'h0160), 16'h000a);
    run1(16'h0022);
    check(at(16'h0172), 16'h0000);
  endtask
  task automatic t_double;
    run1(16'h0028);
    check(at(16'h01b0), 16'h0007);
    check(at(16'h01a0), 16'h0003);
    run1(16'h002c);
    run1(16'h002e);
    check(at(16'h0120), 16'h0000);
  endtask
  task automatic t_bytes;
    run1(16'h0030);
    check(stack_pointer, 16'h0142);
    run1(16'h0032);
    check(stack_pointer, 16'h0140);
    run1(16'h0036);
  endtask
  // reset in mid-instruction clears busy, mem_req, mem_write and both register outputs
  task automatic t_reset;
    start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 resetn = 1'b0;
    #1 check({busy, mem_req, mem_write, 13'h0000}, 16'h0000);
    check(program_counter, 16'h0000);
    check(stack_pointer, 16'h0000);
    repeat (10) @(posedge sys_clk);
    #1 resetn = 1'b1;
  endtask
  //==========================================
  // main sequence, fast then slow memory
  initial
  begin
    fails = 0;
    checks_done = 0;
    start = 1'b0;
    resetn = 1'b0;
    lat = 4'h0;
    repeat (10) @(posedge sys_clk);
    #1 resetn = 1'b1;
    for (int pass = 0; pass < 2; pass++)
    begin
      lat = 4'(pass * 3);
      load_mem;
      t_setup;
      t_deferred;
      t_pc_modes;
      t_double;
      t_bytes;
      t_reset;
    end
    final_report;
  end
  initial
  begin
    repeat (6000) @(posedge sys_clk);
    fails++;
    final_report;
  end
endmodule
